/* core/peis_defs.svh */
// peis_defs.svh: register offsets, field positions and reset values of the event interrupt block
// assumes inclusion by bare name from core/
`ifndef PEIS_DEFS_SVH
`define PEIS_DEFS_SVH

// printed offsets are not multiples of four: index, byte address = 4 * index
`define PEIS_IDX_FLAGS_A 8'h12
`define PEIS_IDX_FLAGS_B 8'h13
`define PEIS_IDX_PHY_CTRL 8'h11
`define PEIS_IDX_ENERGY_CFG 12'h101
`define PEIS_IDX_STATUS 8'h10
`define PEIS_IDX_IRQ_STATUS 8'h20
`define PEIS_IDX_IRQ_MASK 8'h21
`define PEIS_ADDR_W 12

`define PEIS_RST_FLAGS_A 16'h0000
`define PEIS_RST_FLAGS_B 16'h0000
`define PEIS_RST_IRQ_MASK 2'h0

// flags_a layout
`define PEIS_EN_LSB 0
`define PEIS_LINK_QUAL_EN_BIT 7
`define PEIS_FLAG_LSB 8
`define PEIS_NUM_EVENTS 7
// event order, low to high
`define PEIS_EV_RX_ERR_HALF 0
`define PEIS_EV_FALSE_CARRIER_HALF 1
`define PEIS_EV_TRAINING 2
`define PEIS_EV_ESD 3
`define PEIS_EV_WAKE 4
`define PEIS_EV_LINK 5
`define PEIS_EV_ENERGY 6

// phy control bits
`define PEIS_POL_BIT 3
`define PEIS_FORCE_BIT 2
`define PEIS_MASTER_EN_BIT 1
`define PEIS_RST_POL 1'h1
`define PEIS_RST_MASTER_EN 1'h1

// energy config bits
`define PEIS_RISING_ONLY_BIT 0

// status register bits
`define PEIS_PIN_LATCH_BIT 7
`define PEIS_LINK_QUAL_BIT 0

// irq status bits
`define PEIS_IRQ_PIN_BIT 0
`define PEIS_IRQ_QUAL_BIT 1

`endif

/* core/peis_pkg.sv */
// peis_pkg.sv: types of the event interrupt block
// assumes nothing outside itself
package peis_pkg;

	typedef struct packed {
		logic energy_det;
		logic link_up;
		logic wake_packet;
		logic esd_detect;
		logic training_done;
		logic false_carrier_half;
		logic rx_err_half;
		logic link_quality_change;
	} peis_events_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} peis_wreq_t;

	typedef enum logic [1:0] {
		PEIS_RD_IDLE = 2'b00,
		PEIS_RD_RESP = 2'b01
	} peis_rd_state_t;

endpackage

/* core/peis_edge_detect.sv */
// peis_edge_detect.sv: rising and falling edge pulses of a level
// assumes the level is synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module peis_edge_detect
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic level,
	output logic rise,
	output logic fall
);
	logic last_reg;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			last_reg <= 1'b0;
		else
			last_reg <= level;
	end

	assign rise = level & ~last_reg;
	assign fall = ~level & last_reg;
endmodule
`default_nettype wire

/* core/peis_pin_driver.sv */
// peis_pin_driver.sv: interrupt pin level and output enable
// assumes the request is a registered level
`timescale 1ns/1ps
`default_nettype none
module peis_pin_driver
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic request,
	input wire logic master_en,
	input wire logic polarity,
	output logic pin_o,
	output logic pin_oe_n
);
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_o <= 1'b1;
			pin_oe_n <= 1'b1;
		end
		else
		begin
			pin_oe_n <= ~master_en;
			pin_o <= request ^ polarity;
		end
	end
endmodule
`default_nettype wire

/* core/peis_top.sv */
// peis_top.sv: event flag and enable register with interrupt pin, AXI4-Lite slave
// assumes event inputs synchronous to sys_clk, pulses one cycle, levels held
//
// Overview of operation
// - energy flag on both edges, rising-only optional
// - link change flag latched, cleared by read
// - wake packet flag latched, cleared by read
// - esd flag latched, cleared by read
// - training complete flag latched, cleared by read
// - false carrier half-full flag, cleared by read
// - receive error half-full flag, cleared by read
// - enables bits 0-6 match flags 8-14
// - bit 7 enables link quality interrupt
// - register at 12h, resets zero, bit 15 reserved
// - pin driven only while master enable set
// - polarity bit picks idle level, resets one
// - pin-asserted latch cleared by reading 12h
`timescale 1ns/1ps
`default_nettype none
`include "peis_defs.svh"
module peis_top
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire peis_pkg::peis_events_t events,
	output logic irq_pin_o,
	output logic irq_pin_oe_n,
	output logic irq
);
	import peis_pkg::*;

	localparam int NE = `PEIS_NUM_EVENTS;
	localparam logic [15:0] RST_FLAGS_A = `PEIS_RST_FLAGS_A;

	logic [NE-1:0] flag_reg;
	logic [NE-1:0] flag_next;
	logic [NE-1:0] enable_reg;
	logic link_qual_en_reg;
	logic pol_reg;
	logic master_en_reg;
	logic force_reg;
	logic rising_only_reg;
	logic pin_latch_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic irq_request_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	peis_rd_state_t rd_state_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [NE-1:0] ev_set;
	logic energy_rise;
	logic energy_fall;
	logic link_rise;
	logic link_fall;
	logic qual_rise;
	logic qual_fall;
	logic wr_fire;
	logic rd_fire;
	logic rd_flags_a;
	logic [15:0] wr_val;
	logic [15:0] flags_a_view;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;
	peis_wreq_t wreq;

	function automatic logic [7:0] reg_index(input logic [11:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] idx);
		is_reg = (a[11:2] == idx[9:0]) && (a[1:0] == 2'b00);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// event sources

	peis_edge_detect u_energy
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.level(events.energy_det),
		.rise(energy_rise),
		.fall(energy_fall)
	);

	peis_edge_detect u_link
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.level(events.link_up),
		.rise(link_rise),
		.fall(link_fall)
	);

	peis_edge_detect u_qual
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.level(events.link_quality_change),
		.rise(qual_rise),
		.fall(qual_fall)
	);

	always_comb
	begin
		ev_set = '0;
		ev_set[`PEIS_EV_ENERGY] = energy_rise | (energy_fall & ~rising_only_reg);
		ev_set[`PEIS_EV_LINK] = link_rise | link_fall;
		ev_set[`PEIS_EV_WAKE] = events.wake_packet;
		ev_set[`PEIS_EV_ESD] = events.esd_detect;
		ev_set[`PEIS_EV_TRAINING] = events.training_done;
		ev_set[`PEIS_EV_FALSE_CARRIER_HALF] = events.false_carrier_half;
		ev_set[`PEIS_EV_RX_ERR_HALF] = events.rx_err_half;
	end

	////////////////////////////////////////////////////////////////////////////
	// bus handshake

	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = (rd_state_reg == PEIS_RD_IDLE);
	assign s_axi_rvalid = (rd_state_reg == PEIS_RD_RESP);
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign rd_flags_a = rd_fire & is_reg(s_axi_araddr, 12'(`PEIS_IDX_FLAGS_A));
	assign wreq = '{addr: aw_addr_reg, data: w_data_reg, strb: w_strb_reg};
	assign wr_val = {wreq.strb[1] ? wreq.data[15:8] : 8'h00,
		wreq.strb[0] ? wreq.data[7:0] : 8'h00};

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? 2'h0 : 2'h2;
			end
			else if (bvalid_reg & s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	always_comb
	begin
		case (reg_index(wreq.addr))
			`PEIS_IDX_FLAGS_A, `PEIS_IDX_FLAGS_B, `PEIS_IDX_PHY_CTRL,
			`PEIS_IDX_STATUS, `PEIS_IDX_IRQ_STATUS, `PEIS_IDX_IRQ_MASK:
				wr_ok = (wreq.addr[11:10] == 2'b00) && (wreq.addr[1:0] == 2'b00);
			default:
				wr_ok = is_reg(wreq.addr, 12'(`PEIS_IDX_ENERGY_CFG));
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// writable control

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			enable_reg <= RST_FLAGS_A[NE-1:0];
			link_qual_en_reg <= 1'b0;
			pol_reg <= `PEIS_RST_POL;
			master_en_reg <= `PEIS_RST_MASTER_EN;
			force_reg <= 1'b0;
			rising_only_reg <= 1'b0;
			irq_mask_reg <= `PEIS_RST_IRQ_MASK;
		end
		else if (wr_fire)
		begin
			if (is_reg(wreq.addr, 12'(`PEIS_IDX_FLAGS_A)))
			begin
				enable_reg <= wr_val[`PEIS_EN_LSB +: NE];
				link_qual_en_reg <= wr_val[`PEIS_LINK_QUAL_EN_BIT];
			end
			if (is_reg(wreq.addr, 12'(`PEIS_IDX_PHY_CTRL)))
			begin
				pol_reg <= wr_val[`PEIS_POL_BIT];
				master_en_reg <= wr_val[`PEIS_MASTER_EN_BIT];
				force_reg <= wr_val[`PEIS_FORCE_BIT];
			end
			if (is_reg(wreq.addr, 12'(`PEIS_IDX_ENERGY_CFG)))
				rising_only_reg <= wr_val[`PEIS_RISING_ONLY_BIT];
			if (is_reg(wreq.addr, 12'(`PEIS_IDX_IRQ_MASK)))
				irq_mask_reg <= wr_val[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latched flags, cleared by reading the flag register

	always_comb
	begin
		flag_next = flag_reg;
		if (rd_flags_a)
			flag_next = '0;
		flag_next = flag_next | ev_set;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			flag_reg <= '0;
		else
			flag_reg <= flag_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt request, pin and pin latch

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_request_reg <= 1'b0;
		else
			irq_request_reg <= (|(flag_next & enable_reg)) | force_reg;
	end

	peis_pin_driver u_pin
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.request(irq_request_reg),
		.master_en(master_en_reg),
		.polarity(pol_reg),
		.pin_o(irq_pin_o),
		.pin_oe_n(irq_pin_oe_n)
	);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			pin_latch_reg <= 1'b0;
		else if (irq_request_reg & master_en_reg)
			pin_latch_reg <= 1'b1;
		else if (rd_flags_a)
			pin_latch_reg <= 1'b0;
	end

	// software interrupt: pin assertion and link quality change, write one to clear
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_status_reg <= 2'h0;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (i == `PEIS_IRQ_PIN_BIT && irq_request_reg && master_en_reg)
					irq_status_reg[i] <= 1'b1;
				else if (i == `PEIS_IRQ_QUAL_BIT && link_qual_en_reg && (qual_rise | qual_fall))
					irq_status_reg[i] <= 1'b1;
				else if (wr_fire && is_reg(wreq.addr, 12'(`PEIS_IDX_IRQ_STATUS)) && wr_val[i])
					irq_status_reg[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(irq_status_reg & irq_mask_reg);
	end

	////////////////////////////////////////////////////////////////////////////
	// read path

	assign flags_a_view = {1'b0, flag_reg, link_qual_en_reg, enable_reg};

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_FLAGS_A)))
			rd_val[15:0] = flags_a_view;
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_FLAGS_B)))
			rd_val[15:0] = `PEIS_RST_FLAGS_B;
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_PHY_CTRL)))
		begin
			rd_val[`PEIS_POL_BIT] = pol_reg;
			rd_val[`PEIS_FORCE_BIT] = force_reg;
			rd_val[`PEIS_MASTER_EN_BIT] = master_en_reg;
		end
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_ENERGY_CFG)))
			rd_val[`PEIS_RISING_ONLY_BIT] = rising_only_reg;
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_STATUS)))
		begin
			rd_val[`PEIS_PIN_LATCH_BIT] = pin_latch_reg;
			rd_val[`PEIS_LINK_QUAL_BIT] = events.link_quality_change;
		end
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_IRQ_STATUS)))
			rd_val[1:0] = irq_status_reg;
		else if (is_reg(s_axi_araddr, 12'(`PEIS_IDX_IRQ_MASK)))
			rd_val[1:0] = irq_mask_reg;
		else
			rd_ok = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_state_reg <= PEIS_RD_IDLE;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
		end
		else
		begin
			case (rd_state_reg)
				PEIS_RD_IDLE:
					if (rd_fire)
					begin
						rd_state_reg <= PEIS_RD_RESP;
						rdata_reg <= rd_val;
						rresp_reg <= rd_ok ? 2'h0 : 2'h2;
					end
				PEIS_RD_RESP:
					if (s_axi_rready)
						rd_state_reg <= PEIS_RD_IDLE;
				default:
					rd_state_reg <= PEIS_RD_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* tb/peis_checker.sv */
// peis_checker.sv: bus and pin assertions on the event interrupt block
// assumes the bind at the foot reaches peis_top
`timescale 1ns/1ps
`default_nettype none
module peis_checker
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_pin_o,
	input wire logic irq_pin_oe_n
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rstn);
logic [11:0] rd_addr_reg;
always_ff @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
		rd_addr_reg <= 12'h000;
	else if (s_axi_arvalid && s_axi_arready)
		rd_addr_reg <= s_axi_araddr;
end
////////////////////////////////////////////////////////////////
a_oe_after_reset: assert property ($rose(rstn) |=> !irq_pin_oe_n)
	else $error("pin not driven after reset");
a_idle_after_reset: assert property ($rose(rstn) |=> irq_pin_o)
	else $error("pin idle level wrong after reset");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
	&& s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write response");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
	|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("no read response");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
	|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
	|-> s_axi_rdata == 32'h0) else $error("error read with data");
a_reserved_zero: assert property (s_axi_rvalid && rd_addr_reg == 12'h048
	|-> s_axi_rdata[31:15] == 17'h0) else $error("reserved bits set");
endmodule
bind peis_top peis_checker peis_checker_i (.*);
`default_nettype wire

/* tb/test_peis_top.sv */
// test_peis_top.sv: directed bench for the event interrupt block
// assumes core/ on the include path
`timescale 1ns/1ps
`default_nettype none
`include "peis_defs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: %h not %h", $time, a, e); end end
module test_peis_top;
import peis_pkg::*;
localparam logic [11:0] A_FLG = 12'h048;
localparam logic [11:0] A_CTL = 12'h044;
localparam logic [11:0] A_STA = 12'h040;
localparam logic [11:0] A_IST = 12'h080;
localparam logic [11:0] A_MSK = 12'h084;
logic sys_clk = 0, rstn = 0;
logic [11:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, rd_d;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic awready, wready, bvalid, arready, rvalid, pin, oe_n, irq;
logic [1:0] bresp, rresp, rd_r, wr_r;
logic [7:0] ev = 0;
int error_cnt = 0, n_checks = 0;
peis_top peis_top_i (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
	.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
	.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
	.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
	.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(rready), .events(ev), .irq_pin_o(pin), .irq_pin_oe_n(oe_n), .irq(irq));
always #12.5 sys_clk = ~sys_clk;
task wrap_up;
	$display("checks %0d mismatches %0d", n_checks, error_cnt);
	if (error_cnt == 0 && n_checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
task tick(input int n);
	repeat (n) @(posedge sys_clk);
endtask
task hang(input int n);
	if (n >= 50)
	begin
		error_cnt++;
		$display("unexpected at %0t: bus hang", $time);
		wrap_up;
	end
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
	int n;
	logic ad, wd;
	ad = 0;
	wd = 0;
	n = 0;
	awaddr <= a;
	wdata <= d;
	awvalid <= 1;
	wvalid <= 1;
	bready <= 1;
	while (!(ad && wd) && n < 50)
	begin
		@(posedge sys_clk);
		if (awvalid && awready) begin ad = 1; awvalid <= 0; end
		if (wvalid && wready) begin wd = 1; wvalid <= 0; end
		n++;
	end
	hang(n);
	n = 0;
	do begin @(posedge sys_clk); n++; end while (!bvalid && n < 50);
	hang(n);
	wr_r = bresp;
	bready <= 0;
	@(posedge sys_clk);
endtask
task rd(input logic [11:0] a);
	int n;
	n = 0;
	araddr <= a;
	arvalid <= 1;
	rready <= 1;
	do begin @(posedge sys_clk); n++; end while (!arready && n < 50);
	hang(n);
	arvalid <= 0;
	n = 0;
	do begin @(posedge sys_clk); n++; end while (!rvalid && n < 50);
	hang(n);
	rd_d = rdata;
	rd_r = rresp;
	rready <= 0;
	@(posedge sys_clk);
endtask
task pulse(input int k);
	ev[k] <= 1;
	@(posedge sys_clk);
	ev[k] <= (k >= 6);
	tick(3);
endtask
////////////////////////////////////////////////////////////////
task t_reset;
	rd(A_FLG); `CHK(rd_d, 32'h0)
	rd(12'h04c); `CHK(rd_d, 32'h0)
	rd(A_CTL); `CHK(rd_d, 32'ha)
	`CHK({pin, oe_n, irq}, 3'b100)
	rd(12'h0f0); `CHK({rd_r, rd_d}, {2'h2, 32'h0})
	wr(12'h0f0, 32'h1); `CHK(wr_r, 2'h2)
	wr(A_FLG, 32'hffff); rd(A_FLG); `CHK(rd_d, 32'hff)
	$display("reset test done");
endtask
task t_events;
	for (int k = 1; k < 8; k++)
	begin
		pulse(k); `CHK(pin, 1'b0)
		rd(A_FLG); `CHK(rd_d, 32'hff | (32'h1 << (7 + k)))
		rd(A_FLG); `CHK(rd_d, 32'hff)
		tick(3); `CHK(pin, 1'b1)
		if (k >= 6)
		begin
			ev[k] <= 0;
			tick(3);
			rd(A_FLG); `CHK(rd_d, 32'hff | (32'h1 << (7 + k)))
			rd(A_FLG);
		end
	end
	wr(12'h404, 32'h1);
	pulse(7); rd(A_FLG); `CHK(rd_d, 32'h40ff)
	ev[7] <= 0;
	tick(3); rd(A_FLG); `CHK(rd_d, 32'hff)
	fork
		rd(A_FLG);
		begin ev[5] <= 1; @(posedge sys_clk); ev[5] <= 0; end
	join
	`CHK(rd_d, 32'hff)
	rd(A_FLG); `CHK(rd_d, 32'h10ff)
	$display("event test done");
endtask
task t_pin;
	tick(3); rd(A_FLG); tick(3); rd(A_FLG);
	pulse(4); rd(A_STA); `CHK(rd_d[7], 1'b1)
	rd(A_FLG); tick(3); rd(A_FLG);
	rd(A_STA); `CHK(rd_d[7], 1'b0)
	wr(A_CTL, 32'h2); tick(3); `CHK(pin, 1'b0)
	pulse(3); `CHK(pin, 1'b1)
	rd(A_FLG); wr(A_CTL, 32'h0); tick(2); `CHK(oe_n, 1'b1)
	wr(A_CTL, 32'ha); tick(3); `CHK({pin, oe_n}, 2'b10)
	wr(A_CTL, 32'he); tick(3); `CHK({pin, oe_n}, 2'b00)
	wr(A_CTL, 32'ha); tick(3); `CHK(pin, 1'b1)
	$display("pin test done");
endtask
task t_irq;
	wr(A_IST, 32'h3); rd(A_IST); `CHK(rd_d, 32'h0)
	wr(A_MSK, 32'h0); pulse(2); tick(2); `CHK(irq, 1'b0)
	rd(A_IST); `CHK(rd_d[0], 1'b1)
	wr(A_MSK, 32'h1); tick(3); `CHK(irq, 1'b1)
	rd(A_FLG); tick(3); rd(A_FLG);
	wr(A_IST, 32'h1); tick(3); `CHK(irq, 1'b0)
	rd(A_IST); `CHK(rd_d, 32'h0)
	ev[0] <= 1; tick(3);
	rd(A_STA); `CHK(rd_d[0], 1'b1)
	rd(A_IST); `CHK(rd_d, 32'h2)
	wr(A_MSK, 32'h2); tick(3); `CHK(irq, 1'b1)
	wr(A_FLG, 32'h7f); ev[0] <= 0; wr(A_IST, 32'h2); tick(3);
	rd(A_IST); `CHK({irq, rd_d}, {1'b0, 32'h0})
	$display("interrupt test done");
endtask
initial
begin
	tick(6);
	rstn <= 1;
	@(posedge sys_clk);
	t_reset;
	t_events;
	t_pin;
	t_irq;
	wrap_up;
end
endmodule
`default_nettype wire
